//--- dv/clock_receiver_model.sv
// downstream clock receiver model: counts rising edges seen on one output
`timescale 1ns/100ps
module clock_receiver_model (
  input  wire logic sys_clk,
  input  wire logic arst_n,
  input  wire logic clr,
  input  wire logic rx_main,
  output int        edges_main
);
  logic main_q; // last sampled level
  // a receiver sees transitions only, so a muted output counts nothing
  always @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      main_q     <= 1'b0;
      edges_main <= 0;
    end else begin
      main_q     <= rx_main;
      edges_main <= clr ? 0 : edges_main + int'(rx_main & !main_q);
    end
  end
endmodule // clock_receiver_model

//--- dv/output_burst_pattern_driver_ctrl_sva.sv
// assertion checker for the burst pattern register block
`timescale 1ns/100ps
`include "burst_ctrl_regs.vh"
module burst_ctrl_checker (
  input wire logic        sys_clk,
  input wire logic        arst_n,
  input wire logic [15:0] reg_addr,
  input wire logic [7:0]  reg_wdata,
  input wire logic        reg_wr,
  input wire logic        reg_rd,
  input wire logic [7:0]  reg_rdata,
  input wire logic        driver_a_output_p,
  input wire logic        driver_a_output_n
);
  localparam logic [15:0] A_ENA = `IDX_EN_A_PAIR << 2; // byte addresses
  localparam logic [15:0] A_ENC = `IDX_EN_C_PAIR << 2;
  localparam logic [15:0] A_RET = `IDX_RETIME_SEL << 2;
  localparam logic [15:0] A_DRV = `IDX_DRV_A_CFG << 2;
  logic [1:0] mode_q; // driver mode as last written
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!arst_n);
  // shadow of the driver mode field, updated at the write edge
  always @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      mode_q <= 2'b00;
    end else if (reg_wr && reg_addr == A_DRV) begin
      mode_q <= reg_wdata[4:3];
    end
  end
  idle_read_zero_a: assert property (!reg_rd |=> reg_rdata == 8'h00)
    else $error("read data not zero outside a read");
  unmapped_read_a: assert property (reg_rd && reg_addr[15:8] == 8'h40 |=> reg_rdata == 8'h00)
    else $error("unmapped read not zero");
  c_pair_back_a: assert property (reg_wr && reg_addr == A_ENC ##1 reg_rd && reg_addr == A_ENC
    |=> reg_rdata == ($past(reg_wdata, 2) & 8'h0f))
    else $error("c pair enables read back wrong");
  a_main_back_a: assert property (reg_wr && reg_addr == A_ENA ##1 reg_rd && reg_addr == A_ENA
    |=> (reg_rdata & 8'h03) == ($past(reg_wdata, 2) & 8'h03))
    else $error("a main enables read back wrong");
  retime_reserved_a: assert property (reg_rd && reg_addr == A_RET |=> reg_rdata[7:1] == 7'h00)
    else $error("retime reserved bits not zero");
  drv_reserved_a: assert property (reg_rd && reg_addr == A_DRV |=> reg_rdata[7:6] == 2'b00)
    else $error("driver reserved bits not zero");
  same_source_a: assert property (mode_q == 2'b01 && $past(mode_q) == 2'b01
    |-> driver_a_output_n == driver_a_output_p)
    else $error("single ended pins differ in same source mode");
  diff_pair_a: assert property (mode_q == 2'b00 && $past(mode_q) == 2'b00 && driver_a_output_p
    |-> !driver_a_output_n)
    else $error("differential pins both high");
endmodule // burst_ctrl_checker
bind output_burst_pattern_driver_ctrl burst_ctrl_checker chk_u (
  .sys_clk(sys_clk), .arst_n(arst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
  .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
  .driver_a_output_p(driver_a_output_p), .driver_a_output_n(driver_a_output_n));

//--- dv/output_burst_pattern_driver_ctrl_test.sv
// self-checking bench for the burst pattern register block
`timescale 1ns/100ps
`include "burst_ctrl_regs.vh"
module output_burst_pattern_driver_ctrl_test;
  localparam logic [15:0] A_GAP = `IDX_GAP << 2; // byte addresses
  localparam logic [15:0] A_REQ = `IDX_REQUEST << 2;
  localparam logic [15:0] A_ENA = `IDX_EN_A_PAIR << 2;
  localparam logic [15:0] A_ENC = `IDX_EN_C_PAIR << 2;
  localparam logic [15:0] A_RET = `IDX_RETIME_SEL << 2;
  localparam logic [15:0] A_DRV = `IDX_DRV_A_CFG << 2;
  localparam logic [15:0] A_TRG = `IDX_TRIG_CTRL << 2;
  localparam logic [15:0] A_STA = `IDX_STATUS << 2;
  logic        sys_clk = 1'b0;
  logic        arst_n = 1'b0;
  logic [15:0] reg_addr = 16'h0000;
  logic [7:0]  reg_wdata = 8'h00;
  logic        reg_wr = 1'b0;
  logic        reg_rd = 1'b0;
  logic        mf_pin = 1'b0;   // external trigger
  logic        int_trig = 1'b0; // internal retimer trigger
  logic [3:0]  div_cnt = 4'h0;  // divide-by-16 phase
  logic        tick = 1'b0;
  logic        lvl = 1'b0;
  logic        clr = 1'b0;
  wire  [7:0]  reg_rdata;
  wire         out_p, out_n, c_main, c_comp;
  wire  [1:0]  drv_cur;         // driver current pins
  wire         hcsl;            // source or sink mode pin
  int          edges_main;
  int          err_total = 0;
  int          n_compared = 0;
  always #5 sys_clk = ~sys_clk;
  // divider source; ratio 16 keeps burst mode legal
  always @(posedge sys_clk) begin
    div_cnt <= div_cnt + 4'h1;
    tick    <= (div_cnt == 4'he);
    lvl     <= (div_cnt == 4'hf) || (div_cnt < 4'h7);
  end
  // a_comp level held low so its pattern is told apart
  output_burst_pattern_driver_ctrl dut_u (
    .sys_clk(sys_clk), .arst_n(arst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .multifunction_pin(mf_pin),
    .internal_retime_trig(int_trig), .div_tick_a_main(tick), .div_tick_a_comp(tick),
    .div_tick_c_main(tick), .div_tick_c_comp(tick), .div_lvl_a_main(lvl),
    .div_lvl_a_comp(1'b0), .div_lvl_c_main(lvl), .div_lvl_c_comp(lvl),
    .driver_a_output_p(out_p), .driver_a_output_n(out_n), .divider_c_main_out(c_main),
    .divider_c_comp_out(c_comp), .drive_current(drv_cur), .hcsl_en(hcsl));
  clock_receiver_model rx_u (.sys_clk(sys_clk), .arst_n(arst_n), .clr(clr),
    .rx_main(c_main), .edges_main(edges_main));
  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      err_total++;
      $display("Error %s expected %0h seen %0h", nm, exp, seen);
    end
  endtask
  task automatic tally_and_finish();
    $display("compared %0d mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  // one-cycle write; an edge passes first if the strobe is still up
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    if (reg_wr === 1'b1) @(posedge sys_clk);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
  endtask
  // read data stand only in the cycle after the strobe
  task automatic rd(input logic [15:0] a, input logic [7:0] exp, input string nm);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    #1 check(nm, reg_rdata, exp);
    @(posedge sys_clk);
  endtask
  // returns at the edge that ends phase v; bounded wait
  task automatic sync(input logic [3:0] v);
    int i;
    i = 0;
    do begin
      @(posedge sys_clk);
      i++;
    end while (div_cnt !== v && i < 20);
    if (i >= 20) begin
      err_total++;
      tally_and_finish();
    end
  endtask
  task automatic clear_rx();
    clr <= 1'b1;
    @(posedge sys_clk);
    clr <= 1'b0;
  endtask
  // watchdog: a hang counts as a mismatch
  initial begin
    repeat (40000) @(posedge sys_clk);
    err_total++;
    tally_and_finish();
  end
  initial begin
    logic [15:0] ra [8];
    logic [7:0]  rv [8];
    logic [7:0]  wv [8];
    logic [7:0]  bv [8];
    logic [7:0]  mv [3];
    int          nh [3];
    int          ne [3];
    int          i, j, ones_m, ones_c, n_hi, n_eq;
    ra = '{A_GAP, A_REQ, A_ENA, A_ENC, A_RET, A_DRV, A_TRG, 16'h4000};
    rv = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h01, 8'h00, 8'h00};
    wv = '{8'hff, 8'hff, 8'hf5, 8'hfa, 8'hff, 8'hff, 8'hfb, 8'hff};
    bv = '{8'hff, 8'h7f, 8'h05, 8'h0a, 8'h01, 8'h3f, 8'h03, 8'h00};
    mv = '{8'h01, 8'h09, 8'h11};
    nh = '{8, 8, 0};
    ne = '{0, 16, 8};
    repeat (2) @(posedge sys_clk);
    arst_n <= 1'b1;
    @(posedge sys_clk);
    for (i = 0; i < 8; i++) rd(ra[i], rv[i], "reset value");
    check("drive pins at reset", {drv_cur, hcsl}, 3'b001);
    $display("reset value test done");
    // reserved bits written as ones; never prbs and burst together
    for (i = 0; i < 8; i++) begin
      wr(ra[i], wv[i]);
      rd(ra[i], bv[i], "readback");
      if (i == 5) check("drive pins written", {drv_cur, hcsl}, 3'b111);
    end
    for (i = 0; i < 7; i++) wr(ra[i], rv[i]);
    $display("readback test done");
    // pseudorandom on both c dividers, one sample per divider cycle
    wr(A_ENC, 8'h0a);
    ones_m = 0;
    ones_c = 0;
    for (i = 0; i < 127; i++) begin
      sync(4'h4);
      ones_m += int'(c_main === 1'b1);
      ones_c += int'(c_comp === 1'b1);
    end
    check("prbs ones c_main", ones_m, 64);
    check("prbs ones c_comp", ones_c, 64);
    wr(A_ENC, 8'h00);
    $display("pseudorandom test done");
    // edge-triggered burst of three pulses from the pin
    wr(A_GAP, 8'h04);
    wr(A_REQ, 8'h03);
    wr(A_TRG, 8'h01);
    wr(A_ENC, 8'h01);
    clear_rx();
    repeat (64) @(posedge sys_clk);
    check("muted before request", edges_main, 0);
    sync(4'hf);
    mf_pin <= 1'b1;
    repeat (160) @(posedge sys_clk);
    check("edge burst pulses", edges_main, 3);
    mf_pin <= 1'b0;
    wr(A_REQ, 8'h42);
    clear_rx();
    mf_pin <= 1'b1;
    repeat (320) @(posedge sys_clk);
    mf_pin <= 1'b0;
    check("level bursts repeat", edges_main >= 4, 1);
    repeat (160) @(posedge sys_clk);
    clear_rx();
    repeat (160) @(posedge sys_clk);
    check("bursts stop", edges_main, 0);
    // internal retimer as source: the pin no longer triggers
    wr(A_RET, 8'h01);
    wr(A_REQ, 8'h01);
    clear_rx();
    mf_pin <= 1'b1;
    repeat (64) @(posedge sys_clk);
    check("pin ignored", edges_main, 0);
    sync(4'hf);
    int_trig <= 1'b1;
    repeat (64) @(posedge sys_clk);
    check("internal trigger", edges_main, 1);
    int_trig <= 1'b0;
    mf_pin   <= 1'b0;
    wr(A_RET, 8'h00);
    wr(A_ENC, 8'h00);
    wr(A_TRG, 8'h00);
    $display("burst test done");
    // driver modes: differential, same source, split dividers
    for (j = 0; j < 3; j++) begin
      wr(A_DRV, mv[j]);
      repeat (20) @(posedge sys_clk);
      n_hi = 0;
      n_eq = 0;
      repeat (16) begin
        @(posedge sys_clk);
        n_hi += int'(out_n === 1'b1);
        n_eq += int'(out_n === out_p);
      end
      check("driver n high", n_hi, nh[j]);
      check("driver n equals p", n_eq, ne[j]);
    end
    $display("driver mode test done");
    // mute while level high: bypass drops at once, retimed waits for low
    for (j = 0; j < 2; j++) begin
      wr(A_DRV, (j == 0) ? 8'h21 : 8'h01);
      sync(4'hf);
      wr(A_TRG, 8'h04);
      // mute flop, pattern flop and pin flop: three edges after the write
      repeat (3) @(posedge sys_clk);
      #1 check("mute timing", out_p, j);
      sync(4'h2);
      #1 check("mute held", out_p, 0);
      @(posedge sys_clk);
      rd(A_STA, 8'h03, "mute status");
      wr(A_TRG, 8'h00);
    end
    $display("mute test done");
    tally_and_finish();
  end
endmodule // output_burst_pattern_driver_ctrl_test

//--- src/burst_ctrl_regs.vh
// register offsets, field positions and reset values for the burst pattern block
`ifndef BURST_CTRL_REGS_VH
`define BURST_CTRL_REGS_VH
// register indices; byte address is four times the index
`define IDX_GAP          16'h10d2
`define IDX_REQUEST      16'h10d3
`define IDX_EN_A_PAIR    16'h10d4
`define IDX_EN_C_PAIR    16'h10d5
`define IDX_RETIME_SEL   16'h10d6
`define IDX_DRV_A_CFG    16'h10d7
`define IDX_TRIG_CTRL    16'h10e0
`define IDX_STATUS       16'h10e1
// field positions
`define F_PRBS_MAIN      1
`define F_BURST_MAIN     0
`define F_PRBS_COMP      3
`define F_BURST_COMP     2
`define F_REQ_MODE       6
`define F_RETIME_INT     0
`define F_BYPASS_MUTE    5
`define F_DRV_MODE_HI    4
`define F_DRV_MODE_LO    3
`define F_CUR_HI         2
`define F_CUR_LO         1
`define F_HCSL           0
`define F_TRIG_PIN_SEL   0
`define F_TRIG_SW        1
`define F_MUTE_A         2
// reset values
`define RST_GAP          8'h00
`define RST_REQUEST      8'h00
`define RST_EN_PAIR      4'h0
`define RST_RETIME_SEL   1'b0
`define RST_DRV_A_CFG    6'h01
`define RST_TRIG_CTRL    3'h0
// driver mode codes
`define DRV_DIFF         2'b00
`define DRV_SE_SAME      2'b01
`define DRV_SE_SPLIT     2'b10
// pseudorandom generator seed
`define PRBS_SEED        7'h7f
`endif

//--- src/divider_pattern_gen.v
// one divider's pattern path: pseudorandom, counted burst and mute retiming
`timescale 1ns/100ps
`include "burst_ctrl_regs.vh"
module divider_pattern_gen (
  sys_clk,
  arst_n,
  div_tick,
  div_level,
  prbs_en,
  burst_en,
  trig,
  req_mode,
  burst_count,
  gap_count,
  mute_req,
  mute_bypass,
  pat_out,
  muted
);
  input  wire       sys_clk;      // block clock
  input  wire       arst_n;       // async reset, active low
  input  wire       div_tick;     // one pulse per divider output cycle
  input  wire       div_level;    // raw divider output level
  input  wire       prbs_en;      // pseudorandom pattern on
  input  wire       burst_en;     // counted burst mode on
  input  wire       trig;         // burst request, already source-selected
  input  wire       req_mode;     // 0 edge, 1 level with gaps
  input  wire [5:0] burst_count;  // pulses per burst
  input  wire [7:0] gap_count;    // divider cycles between bursts
  input  wire       mute_req;     // channel mute request
  input  wire       mute_bypass;  // 1 mutes at once, no retiming
  output reg        pat_out;      // pattern output level
  output reg        muted;        // mute actually applied

  // one-hot burst states
  localparam [2:0] S_IDLE  = 3'b001;
  localparam [2:0] S_BURST = 3'b010;
  localparam [2:0] S_GAP   = 3'b100;

  reg  [2:0] state_q;   // burst state
  reg  [6:0] lfsr_q;    // prbs7 shift register
  reg  [7:0] cnt_q;     // pulse or gap counter
  reg        trig_q;    // trigger of last cycle, for edge detect
  wire       trig_rise; // trigger rising edge
  wire       fb;        // lfsr feedback

  assign trig_rise = trig & ~trig_q;
  assign fb        = lfsr_q[6] ^ lfsr_q[5];

  // prbs advances only once per divider cycle
  always @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      lfsr_q <= `PRBS_SEED;
    end else if (prbs_en && div_tick) begin
      lfsr_q <= {lfsr_q[5:0], fb};
    end
  end

  // burst sequencer; pulses and gaps counted in divider cycles
  always @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      state_q <= S_IDLE;
      cnt_q   <= 8'h00;
      trig_q  <= 1'b0;
    end else begin
      trig_q <= trig;
      if (!burst_en) begin
        state_q <= S_IDLE;
        cnt_q   <= 8'h00;
      end else begin
        case (state_q)
          S_IDLE: begin
            // edge mode starts on a rise, level mode while high
            if ((req_mode ? trig : trig_rise) && burst_count != 6'h00) begin
              state_q <= S_BURST;
              cnt_q   <= {2'b00, burst_count};
            end
          end
          S_BURST: begin
            if (div_tick) begin
              if (cnt_q == 8'h01) begin
                // a zero gap simply goes back to idle
                if (req_mode && trig && gap_count != 8'h00) begin
                  state_q <= S_GAP;
                  cnt_q   <= gap_count;
                end else begin
                  state_q <= S_IDLE;
                  cnt_q   <= 8'h00;
                end
              end else begin
                cnt_q <= cnt_q - 8'h01;
              end
            end
          end
          S_GAP: begin
            if (div_tick) begin
              if (cnt_q == 8'h01) begin
                state_q <= S_IDLE; // level mode re-arms from idle
                cnt_q   <= 8'h00;
              end else begin
                cnt_q <= cnt_q - 8'h01;
              end
            end
          end
          default: begin
            state_q <= S_IDLE;
            cnt_q   <= 8'h00;
          end
        endcase
      end
    end
  end

  // mute: retimed to a low divider level to avoid runts, or immediate
  always @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      muted <= 1'b0;
    end else if (mute_bypass) begin
      muted <= mute_req;
    end else if (!div_level) begin
      muted <= mute_req;
    end
  end

  // output select; burst holds the line low outside bursts
  always @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      pat_out <= 1'b0;
    end else if (muted) begin
      pat_out <= 1'b0;
    end else if (prbs_en) begin
      pat_out <= lfsr_q[6];
    end else if (burst_en) begin
      pat_out <= (state_q == S_BURST) & div_level;
    end else begin
      pat_out <= div_level;
    end
  end
endmodule // divider_pattern_gen

//--- src/output_burst_pattern_driver_ctrl.v
// register bank and pattern control for one clock output channel
//
// The implementer's own choice: the plain strobed port.
`timescale 1ns/100ps
`include "burst_ctrl_regs.vh"
// What this block does
// - prbs enable emits sequence at divider rate
// - burst enable mutes output until burst requested
// - c pair enables at bits 3..0
// - a_main prbs bit1, burst bit0, reset zero
// - retime bit picks pins/registers or internal
// - bypass bit: immediate mute, else retimed
// - mode 00 differential, 01 both from a_main
// - mode 10 separate main and comp dividers
// - mode 0 edge burst, 1 repeats while high
// - six-bit pulse count, eight-bit gap length
module output_burst_pattern_driver_ctrl (
  sys_clk,
  arst_n,
  reg_addr,
  reg_wdata,
  reg_wr,
  reg_rd,
  reg_rdata,
  multifunction_pin,
  internal_retime_trig,
  div_tick_a_main,
  div_tick_a_comp,
  div_tick_c_main,
  div_tick_c_comp,
  div_lvl_a_main,
  div_lvl_a_comp,
  div_lvl_c_main,
  div_lvl_c_comp,
  driver_a_output_p,
  driver_a_output_n,
  divider_c_main_out,
  divider_c_comp_out,
  drive_current,
  hcsl_en
);
  input  wire        sys_clk;              // 100 MHz block clock
  input  wire        arst_n;               // async reset, active low
  input  wire [15:0] reg_addr;             // byte address
  input  wire [7:0]  reg_wdata;            // write data
  input  wire        reg_wr;               // write strobe
  input  wire        reg_rd;               // read strobe
  output reg  [7:0]  reg_rdata;            // read data, cycle after strobe
  input  wire        multifunction_pin;    // external burst trigger
  input  wire        internal_retime_trig; // trigger from internal retimer
  input  wire        div_tick_a_main;      // divider cycle pulses
  input  wire        div_tick_a_comp;
  input  wire        div_tick_c_main;
  input  wire        div_tick_c_comp;
  input  wire        div_lvl_a_main;       // divider output levels
  input  wire        div_lvl_a_comp;
  input  wire        div_lvl_c_main;
  input  wire        div_lvl_c_comp;
  output reg         driver_a_output_p;    // driver a true pin
  output reg         driver_a_output_n;    // driver a complement pin
  output wire        divider_c_main_out;   // pattern from divider_c_main
  output wire        divider_c_comp_out;   // pattern from divider_c_comp
  output wire [1:0]  drive_current;        // driver current code
  output wire        hcsl_en;              // 1 source mode, 0 sink mode

  // byte addresses from register indices
  localparam [15:0] A_GAP    = `IDX_GAP << 2;
  localparam [15:0] A_REQ    = `IDX_REQUEST << 2;
  localparam [15:0] A_EN_A   = `IDX_EN_A_PAIR << 2;
  localparam [15:0] A_EN_C   = `IDX_EN_C_PAIR << 2;
  localparam [15:0] A_RETIME = `IDX_RETIME_SEL << 2;
  localparam [15:0] A_DRV_A  = `IDX_DRV_A_CFG << 2;
  localparam [15:0] A_TRIG   = `IDX_TRIG_CTRL << 2;
  localparam [15:0] A_STAT   = `IDX_STATUS << 2;

  reg  [7:0] gap_q;        // gap length in divider cycles
  reg  [7:0] req_q;        // bit 6 mode, bits 5..0 pulse count
  reg  [3:0] en_a_q;       // a pair prbs and burst enables
  reg  [3:0] en_c_q;       // c pair prbs and burst enables
  reg        retime_int_q; // 1 internal retiming source
  reg  [5:0] drv_a_q;      // bypass, mode, current, hcsl
  reg  [2:0] trig_ctrl_q;  // mute, software trigger, pin select
  reg        trig_src;     // selected burst request
  wire [1:0] drv_mode;     // driver a mode code
  wire       split_mode;   // comp divider in use
  wire       pat_a_main;   // pattern outputs
  wire       pat_a_comp;
  wire       mute_a_main;  // mute status per divider
  wire       mute_a_comp;
  wire       mute_c_main;
  wire       mute_c_comp;
  reg  [7:0] rd_d;         // read mux

  assign drv_mode      = drv_a_q[`F_DRV_MODE_HI:`F_DRV_MODE_LO];
  assign split_mode    = (drv_mode == `DRV_SE_SPLIT);
  assign drive_current = drv_a_q[`F_CUR_HI:`F_CUR_LO];
  assign hcsl_en       = drv_a_q[`F_HCSL];

  // register writes; reserved bits are never stored
  always @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      gap_q        <= `RST_GAP;
      req_q        <= `RST_REQUEST;
      en_a_q       <= `RST_EN_PAIR;
      en_c_q       <= `RST_EN_PAIR;
      retime_int_q <= `RST_RETIME_SEL;
      drv_a_q      <= `RST_DRV_A_CFG;
      trig_ctrl_q  <= `RST_TRIG_CTRL;
    end else if (reg_wr) begin
      if (reg_addr == A_GAP) begin
        gap_q <= reg_wdata;
      end else if (reg_addr == A_REQ) begin
        req_q <= {1'b0, reg_wdata[6:0]};
      end else if (reg_addr == A_EN_A) begin
        // software keeps prbs and burst apart on one divider
        en_a_q <= reg_wdata[3:0];
      end else if (reg_addr == A_EN_C) begin
        en_c_q <= reg_wdata[3:0];
      end else if (reg_addr == A_RETIME) begin
        retime_int_q <= reg_wdata[`F_RETIME_INT];
      end else if (reg_addr == A_DRV_A) begin
        drv_a_q <= reg_wdata[5:0];
      end else if (reg_addr == A_TRIG) begin
        trig_ctrl_q <= reg_wdata[2:0];
      end
    end
  end

  // burst request source: pin or register, or internal retimer
  always @* begin
    if (retime_int_q) begin
      trig_src = internal_retime_trig;
    end else if (trig_ctrl_q[`F_TRIG_PIN_SEL]) begin
      trig_src = multifunction_pin;
    end else begin
      trig_src = trig_ctrl_q[`F_TRIG_SW];
    end
  end

  // read mux; reserved bits and unmapped addresses read zero
  always @* begin
    rd_d = 8'h00;
    if (reg_addr == A_GAP) begin
      rd_d = gap_q;
    end else if (reg_addr == A_REQ) begin
      rd_d = req_q;
    end else if (reg_addr == A_EN_A) begin
      rd_d = {4'h0, en_a_q};
    end else if (reg_addr == A_EN_C) begin
      rd_d = {4'h0, en_c_q};
    end else if (reg_addr == A_RETIME) begin
      rd_d = {7'h00, retime_int_q};
    end else if (reg_addr == A_DRV_A) begin
      rd_d = {2'b00, drv_a_q};
    end else if (reg_addr == A_TRIG) begin
      rd_d = {5'h00, trig_ctrl_q};
    end else if (reg_addr == A_STAT) begin
      // live mute state of each divider path
      rd_d = {4'h0, mute_c_comp, mute_c_main, mute_a_comp, mute_a_main};
    end
  end

  // read data stands one cycle after the strobe only
  always @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      reg_rdata <= 8'h00;
    end else if (reg_rd) begin
      reg_rdata <= rd_d;
    end else begin
      reg_rdata <= 8'h00;
    end
  end

  // divider_a_main: always feeds driver a
  divider_pattern_gen u_a_main (
    .sys_clk     (sys_clk),
    .arst_n      (arst_n),
    .div_tick    (div_tick_a_main),
    .div_level   (div_lvl_a_main),
    .prbs_en     (en_a_q[`F_PRBS_MAIN]),
    .burst_en    (en_a_q[`F_BURST_MAIN]),
    .trig        (trig_src),
    .req_mode    (req_q[`F_REQ_MODE]),
    .burst_count (req_q[5:0]),
    .gap_count   (gap_q),
    .mute_req    (trig_ctrl_q[`F_MUTE_A]),
    .mute_bypass (drv_a_q[`F_BYPASS_MUTE]),
    .pat_out     (pat_a_main),
    .muted       (mute_a_main)
  );

  // divider_a_comp: only live in split mode, muted otherwise
  divider_pattern_gen u_a_comp (
    .sys_clk     (sys_clk),
    .arst_n      (arst_n),
    .div_tick    (div_tick_a_comp),
    .div_level   (div_lvl_a_comp),
    .prbs_en     (en_a_q[`F_PRBS_COMP]),
    .burst_en    (en_a_q[`F_BURST_COMP]),
    .trig        (trig_src),
    .req_mode    (req_q[`F_REQ_MODE]),
    .burst_count (req_q[5:0]),
    .gap_count   (gap_q),
    .mute_req    (trig_ctrl_q[`F_MUTE_A] | ~split_mode),
    .mute_bypass (drv_a_q[`F_BYPASS_MUTE]),
    .pat_out     (pat_a_comp),
    .muted       (mute_a_comp)
  );

  // divider_c_main: burst assumes ratio of eight or more
  divider_pattern_gen u_c_main (
    .sys_clk     (sys_clk),
    .arst_n      (arst_n),
    .div_tick    (div_tick_c_main),
    .div_level   (div_lvl_c_main),
    .prbs_en     (en_c_q[`F_PRBS_MAIN]),
    .burst_en    (en_c_q[`F_BURST_MAIN]),
    .trig        (trig_src),
    .req_mode    (req_q[`F_REQ_MODE]),
    .burst_count (req_q[5:0]),
    .gap_count   (gap_q),
    .mute_req    (1'b0),
    .mute_bypass (1'b0),
    .pat_out     (divider_c_main_out),
    .muted       (mute_c_main)
  );

  // divider_c_comp
  divider_pattern_gen u_c_comp (
    .sys_clk     (sys_clk),
    .arst_n      (arst_n),
    .div_tick    (div_tick_c_comp),
    .div_level   (div_lvl_c_comp),
    .prbs_en     (en_c_q[`F_PRBS_COMP]),
    .burst_en    (en_c_q[`F_BURST_COMP]),
    .trig        (trig_src),
    .req_mode    (req_q[`F_REQ_MODE]),
    .burst_count (req_q[5:0]),
    .gap_count   (gap_q),
    .mute_req    (1'b0),
    .mute_bypass (1'b0),
    .pat_out     (divider_c_comp_out),
    .muted       (mute_c_comp)
  );

  // driver a pin forming; reserved code 11 falls back to differential
  always @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      driver_a_output_p <= 1'b0;
      driver_a_output_n <= 1'b0;
    end else begin
      driver_a_output_p <= pat_a_main;
      case (drv_mode)
        `DRV_SE_SAME: begin
          driver_a_output_n <= pat_a_main;
        end
        `DRV_SE_SPLIT: begin
          driver_a_output_n <= pat_a_comp;
        end
        default: begin
          // complement stays low while muted, no glitch to high
          driver_a_output_n <= ~pat_a_main & ~mute_a_main;
        end
      endcase
    end
  end
endmodule // output_burst_pattern_driver_ctrl
